// File: verilog/fcrc_checker.sv
/*
 * Flash CRC signature checker: reads a byte range, folds it into a CRC.
 * Assumes a memory on the same clock that grants requests and returns bytes.
 */
`timescale 1ns/1ps
`include "fcrc_params.svh"

module fcrc_checker (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rst_i,
    // Command
    input wire logic start_i,
    input wire fcrc_pkg::fcrc_cmd_type cmd_i,
    output logic busy_o,
    // Result
    output logic done_o,
    output logic [`FCRC_CRC_W-1:0] crc_o,
    output logic fail_o,
    // Memory read port
    output logic mem_req_o,
    output logic [`FCRC_ADDR_W-1:0] mem_addr_o,
    input wire logic mem_gnt_i,
    input wire logic mem_rvalid_i,
    input wire logic [`FCRC_BYTE_W-1:0] mem_rdata_i
);
    import fcrc_pkg::*;

    function automatic logic [`FCRC_CRC_W-1:0] rev16(input logic [`FCRC_CRC_W-1:0] v);
        logic [`FCRC_CRC_W-1:0] r;
        r = '0;
        for (int i = 0; i < `FCRC_CRC_W; i++) begin
            r[i] = v[`FCRC_CRC_W-1-i];
        end
        return r;
    endfunction

    function automatic logic [`FCRC_BYTE_W-1:0] rev8(input logic [`FCRC_BYTE_W-1:0] v);
        logic [`FCRC_BYTE_W-1:0] r;
        r = '0;
        for (int i = 0; i < `FCRC_BYTE_W; i++) begin
            r[i] = v[`FCRC_BYTE_W-1-i];
        end
        return r;
    endfunction

    fcrc_state_type st_r;
    fcrc_state_type st_nxt;
    logic [`FCRC_ADDR_W-1:0] addr_r;
    logic [`FCRC_LEN_W-1:0] issue_left_r;
    logic [`FCRC_LEN_W-1:0] bytes_left_r;
    logic pending_r;
    logic [`FCRC_CRC_W-1:0] crc_st_r;
    logic [`FCRC_BYTE_W-1:0] sh_r;
    logic [3:0] bit_cnt_r;
    logic [`FCRC_CRC_W-1:0] ref_r;
    logic final_r;
    logic done_r;
    logic fail_r;
    logic [`FCRC_CRC_W-1:0] crc_r;
    logic fifo_in_ready;
    logic fifo_valid;
    logic [`FCRC_BYTE_W-1:0] fifo_data;

    wire logic run = st_r == FCRC_RUN;
    wire logic accept = start_i && !run;
    wire logic grant = mem_req_o && mem_gnt_i;
    wire logic pop = run && fifo_valid && bit_cnt_r == 4'h0 && bytes_left_r != '0;
    wire logic shifting = bit_cnt_r != 4'h0;
    wire logic finish = run && bytes_left_r == '0 && !shifting;
    wire logic fb = crc_st_r[`FCRC_CRC_W-1] ^ sh_r[`FCRC_BYTE_W-1];
    wire logic [`FCRC_CRC_W-1:0] crc_step = {crc_st_r[`FCRC_CRC_W-2:0], 1'b0} ^ (fb ? `FCRC_POLY : '0);
    wire logic [`FCRC_CRC_W-1:0] crc_final = rev16(crc_st_r);

    assign mem_req_o = run && issue_left_r != '0 && !pending_r && fifo_in_ready;
    assign mem_addr_o = addr_r;
    assign busy_o = run;
    assign done_o = done_r;
    assign crc_o = crc_r;
    assign fail_o = fail_r;

    always_comb begin
        st_nxt = st_r;
        case (st_r)
            FCRC_IDLE: st_nxt = accept ? FCRC_RUN : FCRC_IDLE;
            FCRC_RUN: st_nxt = finish ? FCRC_IDLE : FCRC_RUN;
            default: st_nxt = FCRC_IDLE;
        endcase
    end

    fcrc_fifo #(
        .WIDTH(`FCRC_BYTE_W),
        .DEPTH(`FCRC_FIFO_DEPTH)
    ) u_fifo (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .in_valid_i(mem_rvalid_i && pending_r),
        .in_data_i(mem_rdata_i),
        .in_ready_o(fifo_in_ready),
        .out_valid_o(fifo_valid),
        .out_data_o(fifo_data),
        .out_ready_i(pop)
    );

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            st_r <= FCRC_IDLE;
            addr_r <= '0;
            issue_left_r <= '0;
            bytes_left_r <= '0;
            pending_r <= 1'b0;
            ref_r <= '0;
            final_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            if (accept) begin
                addr_r <= cmd_i.start_addr;
                issue_left_r <= cmd_i.length;
                bytes_left_r <= cmd_i.length;
                ref_r <= cmd_i.ref_crc;
                final_r <= cmd_i.final_chk;
            end else begin
                addr_r <= grant ? addr_r + 1'b1 : addr_r;
                issue_left_r <= grant ? issue_left_r - 1'b1 : issue_left_r;
                bytes_left_r <= pop ? bytes_left_r - 1'b1 : bytes_left_r;
            end
            pending_r <= grant || (pending_r && !mem_rvalid_i);
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            crc_st_r <= `FCRC_SEED_ZERO;
            sh_r <= '0;
            bit_cnt_r <= 4'h0;
        end else begin
            if (accept) begin
                crc_st_r <= rev16(cmd_i.seed);
            end else if (shifting) begin
                crc_st_r <= crc_step;
            end
            if (pop) begin
                sh_r <= rev8(fifo_data);
                bit_cnt_r <= `FCRC_BIT_LAST;
            end else if (shifting) begin
                sh_r <= {sh_r[`FCRC_BYTE_W-2:0], 1'b0};
                bit_cnt_r <= bit_cnt_r - 4'h1;
            end
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            done_r <= 1'b0;
            fail_r <= 1'b0;
            crc_r <= '0;
        end else begin
            done_r <= finish;
            crc_r <= finish ? crc_final : crc_r;
            if (finish && final_r && crc_final != ref_r) begin
                fail_r <= 1'b1;
            end else if (accept) begin
                fail_r <= 1'b0;
            end
        end
    end

    done_pulse_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        done_o |=> !done_o)
        else $error("Done held longer than one cycle");

    addr_step_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        grant && !accept |=> mem_addr_o == $past(mem_addr_o) + 32'h1)
        else $error("Read address not ascending");

    seed_load_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        accept |=> crc_st_r == rev16($past(cmd_i.seed)))
        else $error("Seed not loaded");

    byte_steps_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        pop |=> bit_cnt_r == 4'h8 ##7 bit_cnt_r == 4'h1 ##1 bit_cnt_r == 4'h0)
        else $error("Byte not folded in eight steps");

    out_reverse_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        finish |=> done_o && crc_o == rev16($past(crc_st_r)))
        else $error("Result not bit-reversed");

    fail_cause_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        done_o && final_r && crc_o != ref_r |-> fail_o)
        else $error("Mismatch not flagged");

    fail_clear_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        accept |=> !fail_o)
        else $error("Failure not cleared at start");

    fail_hold_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        fail_o && !accept |=> fail_o)
        else $error("Failure dropped early");

    poly_step_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        shifting && !accept && crc_st_r[15] != sh_r[7] |=> crc_st_r == ({$past(crc_st_r[14:0]), 1'b0} ^ 16'h1021))
        else $error("Polynomial not applied");

    req_hold_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        mem_req_o && !mem_gnt_i |=> mem_req_o && $stable(mem_addr_o))
        else $error("Read request dropped before grant");

    crc_hold_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        !done_o |-> $stable(crc_o))
        else $error("Result changed without done");
endmodule // fcrc_checker

// File: inc/fcrc_params.svh
/*
 * Constants of the flash CRC signature checker.
 * Assumes inclusion by the package, the checker and the testbench.
 */
`ifndef FCRC_PARAMS_SVH
`define FCRC_PARAMS_SVH

`define FCRC_POLY 16'h1021
`define FCRC_SEED_ZERO 16'h0000
`define FCRC_CRC_W 16
`define FCRC_ADDR_W 32
`define FCRC_LEN_W 32
`define FCRC_BYTE_W 8
`define FCRC_FIFO_DEPTH 8
`define FCRC_BIT_LAST 4'h8

`endif

// File: inc/fcrc_pkg.sv
/*
 * Types of the flash CRC signature checker.
 * Assumes fcrc_params.svh is on the include path.
 */
`include "fcrc_params.svh"

package fcrc_pkg;
    typedef struct packed {
        logic [`FCRC_ADDR_W-1:0] start_addr;
        logic [`FCRC_LEN_W-1:0] length;
        logic [`FCRC_CRC_W-1:0] seed;
        logic [`FCRC_CRC_W-1:0] ref_crc;
        logic final_chk;
    } fcrc_cmd_type;

    typedef enum logic [0:0] {
        FCRC_IDLE = 1'b0,
        FCRC_RUN = 1'b1
    } fcrc_state_type;
endpackage

// File: verilog/fcrc_fifo.sv
/*
 * Byte FIFO with a registered output stage.
 * Assumes one clock and an asynchronous active-high reset.
 */
`timescale 1ns/1ps

module fcrc_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rst_i,
    // Filling side
    input wire logic in_valid_i,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic in_ready_o,
    // Draining side
    output logic out_valid_o,
    output logic [WIDTH-1:0] out_data_o,
    input wire logic out_ready_i
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0] wp_r;
    logic [AW-1:0] rp_r;
    logic [AW:0] cnt_r;
    logic ov_r;
    logic [WIDTH-1:0] od_r;

    wire logic push = in_valid_i && in_ready_o;
    wire logic load = (cnt_r != '0) && (!ov_r || out_ready_i);
    wire logic [AW:0] cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(load);

    assign in_ready_o = cnt_r != (AW+1)'(DEPTH);
    assign out_valid_o = ov_r;
    assign out_data_o = od_r;

    always_ff @(posedge mclk_i) begin
        if (push) begin
            mem_r[wp_r] <= in_data_i;
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
            ov_r <= 1'b0;
            od_r <= '0;
        end else begin
            wp_r <= push ? wp_r + 1'b1 : wp_r;
            rp_r <= load ? rp_r + 1'b1 : rp_r;
            cnt_r <= cnt_nxt;
            ov_r <= load || (ov_r && !out_ready_i);
            od_r <= load ? mem_r[rp_r] : od_r;
        end
    end

    no_overflow_a: assert property (@(posedge mclk_i) disable iff (rst_i)
        in_valid_i |-> in_ready_o)
        else $error("Byte pushed into full FIFO");
endmodule // fcrc_fifo

// File: sim/fcrc_mem_model.sv
/* Byte-wide flash model for the CRC checker.
   Assumes the checker's clock and reset; slow_i adds grant wait and latency. */
`timescale 1ns/1ps
module fcrc_mem_model (
    // Clock, reset and pace
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic slow_i,
    // Read port
    input wire logic req_i,
    input wire logic [31:0] addr_i,
    output logic gnt_o,
    output logic rvalid_o,
    output logic [7:0] rdata_o
);
    logic [1:0] pace_r;
    logic [1:0] lat_r;
    logic [7:0] data_r;
    logic [7:0] last_r;
    // One read outstanding; slow mode grants one cycle in four
    assign gnt_o = req_i && lat_r == 2'h0 && (!slow_i || pace_r == 2'h3);
    assign rvalid_o = lat_r == 2'h1;
    // Released data line shows the inverse of the last byte
    assign rdata_o = rvalid_o ? data_r : ~last_r;
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            pace_r <= 2'h0;
            lat_r <= 2'h0;
            data_r <= 8'h00;
            last_r <= 8'h00;
        end else begin
            pace_r <= pace_r + 2'h1;
            if (gnt_o) begin
                lat_r <= slow_i ? 2'h3 : 2'h1;
                data_r <= addr_i[7:0] + 8'h31;
            end else if (lat_r != 2'h0) begin
                lat_r <= lat_r - 2'h1;
            end
            if (rvalid_o) begin
                last_r <= data_r;
            end
        end
    end
endmodule // fcrc_mem_model

// File: sim/fcrc_testbench.sv
/* Self-checking bench of the CRC checker.
   Assumes fcrc_pkg, the params header and the flash model. */
`timescale 1ns/1ps
`include "fcrc_params.svh"
module testbench;
    import fcrc_pkg::*;
    typedef struct {
        logic [31:0] a;
        logic [31:0] n;
        logic [15:0] s;
        logic f;
        logic m;
    } fcrc_row_type;
    fcrc_row_type rows [5] = '{'{32'h7fe, 32'h4, 16'h0, 1'b1, 1'b1}, '{32'h100, 32'h1, 16'h0, 1'b1, 1'b1},
        '{32'h3f0, 32'h14, 16'h1234, 1'b0, 1'b0}, '{32'h10, 32'h0, 16'habcd, 1'b1, 1'b1},
        '{32'h55, 32'h5, 16'h0, 1'b1, 1'b0}};
    logic mclk, rst, start, busy, done, fail, req, gnt, rvalid, slow;
    logic [15:0] crc;
    logic [15:0] e;
    logic [31:0] addr;
    logic [31:0] next_addr;
    logic [7:0] rdata;
    fcrc_cmd_type cmd;
    int fails;
    int checks_done;
    fcrc_checker fcrc_checker_i (.mclk_i(mclk), .rst_i(rst), .start_i(start), .cmd_i(cmd), .busy_o(busy),
        .done_o(done), .crc_o(crc), .fail_o(fail), .mem_req_o(req), .mem_addr_o(addr), .mem_gnt_i(gnt),
        .mem_rvalid_i(rvalid), .mem_rdata_i(rdata));
    fcrc_mem_model fcrc_mem_model_i (.mclk_i(mclk), .rst_i(rst), .slow_i(slow), .req_i(req),
        .addr_i(addr), .gnt_o(gnt), .rvalid_o(rvalid), .rdata_o(rdata));
    always #12.5 mclk = ~mclk;
    task automatic complete_run;
        $display("checks %0d fails %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // Reflected CRC over the model's contents
    function automatic logic [15:0] ref_crc(input logic [15:0] s, input logic [31:0] a, input logic [31:0] n);
        logic [15:0] c;
        logic [15:0] p;
        c = s;
        p = {<<{`FCRC_POLY}};
        for (int i = 0; i < n; i++) begin
            c ^= {8'h00, 8'(a + i + 32'h31)};
            for (int b = 0; b < 8; b++) c = c[0] ? (c >> 1) ^ p : c >> 1;
        end
        return c;
    endfunction
    // Issue a command and wait for its completion
    task automatic run(input logic [31:0] a, input logic [31:0] n, input logic [15:0] s, input logic f,
        input logic [15:0] r);
        int k;
        k = 0;
        while (busy !== 1'b0 && k < 2000) begin @(posedge mclk); #1 k++; end
        if (k >= 2000) begin fails++; complete_run; end
        next_addr = a;
        cmd = '{a, n, s, r, f};
        start = 1'b1;
        @(posedge mclk);
        #1 start = 1'b0;
        check(busy, 1'b1);
        k = 0;
        while (done !== 1'b1 && k < 2000) begin @(posedge mclk); #1 k++; end
        if (k >= 2000) begin fails++; complete_run; end
        check(busy, 1'b0);
    endtask
    always @(posedge mclk) if (req && gnt) begin
        check(addr, next_addr);
        next_addr = next_addr + 32'h1;
    end
    initial begin
        mclk = 0; rst = 1; start = 0; slow = 0; cmd = '0; fails = 0; checks_done = 0; next_addr = 0;
        repeat (10) @(posedge mclk);
        #1 rst = 0;
        check({busy, done, fail, req, crc}, 32'h0);
        check(addr, 32'h0);
        run(32'h0, 32'h9, 16'h0, 1'b1, 16'h2189);
        check(crc, 16'h2189);
        check(fail, 1'b0);
        $display("test known vector done");
        foreach (rows[i]) begin
            e = ref_crc(rows[i].s, rows[i].a, rows[i].n);
            run(rows[i].a, rows[i].n, rows[i].s, rows[i].f, rows[i].m ? e : ~e);
            check(crc, e);
            check(fail, rows[i].f & ~rows[i].m);
            $display("test row %0d done", i);
        end
        repeat (20) @(posedge mclk);
        #1 check(fail, 1'b1);
        run(32'h40, 32'h7, 16'h0, 1'b0, 16'h0);
        e = crc;
        check(e, ref_crc(16'h0, 32'h40, 32'h7));
        run(32'h47, 32'h6, e, 1'b1, ref_crc(16'h0, 32'h40, 32'hd));
        check(crc, ref_crc(16'h0, 32'h40, 32'hd));
        check(fail, 1'b0);
        $display("test chaining done");
        slow = 1;
        run(32'h500, 32'hc, 16'h0, 1'b1, 16'h0);
        check(crc, ref_crc(16'h0, 32'h500, 32'hc));
        check(fail, 1'b1);
        slow = 0;
        $display("test slow memory done");
        fork
            run(32'h200, 32'ha, 16'h0, 1'b0, 16'h0);
            begin
                repeat (3) @(posedge mclk);
                #1 start = 1'b1;
                cmd.start_addr = 32'h300;
                @(posedge mclk);
                #1 start = 1'b0;
            end
        join
        check(crc, ref_crc(16'h0, 32'h200, 32'ha));
        $display("test busy start done");
        next_addr = 32'h600;
        cmd = '{32'h600, 32'ha, 16'h0, 16'h0, 1'b1};
        start = 1'b1;
        @(posedge mclk);
        #1 start = 1'b0;
        repeat (5) @(posedge mclk);
        #1 rst = 1;
        #1 check({busy, done, fail, req, crc}, 32'h0);
        check(addr, 32'h0);
        @(posedge mclk);
        #1 rst = 0;
        check({busy, done, fail, req, crc}, 32'h0);
        run(32'h20, 32'h3, 16'h0, 1'b1, ref_crc(16'h0, 32'h20, 32'h3));
        check(crc, ref_crc(16'h0, 32'h20, 32'h3));
        check(fail, 1'b0);
        $display("test mid-run reset done");
        complete_run;
    end
endmodule // testbench
